// file: include/rvi_defines.svh
/*
 * offsets, field positions, reset values, vectors and timing counts
 * of the reset and interrupt vectoring block.
 * assumes inclusion by bare name from the include folder.
 */
`ifndef RVI_DEFINES_SVH
`define RVI_DEFINES_SVH

// register offsets on the plain port
`define RVI_OFF_OPTION 4'h0
`define RVI_OFF_PROMOTE 4'h1
`define RVI_OFF_CCR 4'h2
`define RVI_OFF_ENABLE_LO 4'h3
`define RVI_OFF_ENABLE_HI 4'h4
`define RVI_OFF_WD_SERVICE 4'h5
`define RVI_OFF_VECTOR_LO 4'h6
`define RVI_OFF_VECTOR_HI 4'h7
`define RVI_OFF_SER_STATUS 4'h8
`define RVI_OFF_SER_DATA 4'h9
`define RVI_OFF_PENDING_LO 4'ha
`define RVI_OFF_PENDING_HI 4'hb

// option register fields and reset value
`define RVI_OPT_RESET 8'h10
`define RVI_OPT_SENSE 5
`define RVI_OPT_DELAY 4
`define RVI_OPT_MON_EN 3
`define RVI_OPT_FORCE_MON 2
`define RVI_OPT_RATE_HI 1
`define RVI_OPT_RATE_LO 0
// bits guarded by the write-once window
`define RVI_OPT_ONCE_MASK 8'h37

`define RVI_PROMOTE_RESET 5'h06
`define RVI_CCR_I 4
`define RVI_CCR_X 6
`define RVI_CCR_RESET 8'h50

// watchdog service keys
`define RVI_WD_ARM 8'h55
`define RVI_WD_CLEAR 8'haa

// write-once window after reset, in bus cycles
`define RVI_ONCE_CYCLES 64

// vectors
`define RVI_VEC_POR 16'hfffe
`define RVI_VEC_CLKMON 16'hfffc
`define RVI_VEC_WDOG 16'hfffa
`define RVI_VEC_TRAP 16'hfff8
`define RVI_VEC_SWI 16'hfff6
`define RVI_VEC_NMI 16'hfff4
`define RVI_VEC_IRQ 16'hfff2
`define RVI_VEC_RTI 16'hfff0
`define RVI_VEC_CAP1 16'hffee
`define RVI_VEC_CAP2 16'hffec
`define RVI_VEC_CAP3 16'hffea
`define RVI_VEC_CMP1 16'hffe8
`define RVI_VEC_CMP2 16'hffe6
`define RVI_VEC_CMP3 16'hffe4
`define RVI_VEC_CMP4 16'hffe2
`define RVI_VEC_CAP4 16'hffe0
`define RVI_VEC_TOVF 16'hffde
`define RVI_VEC_AOVF 16'hffdc
`define RVI_VEC_AEDGE 16'hffda
`define RVI_VEC_SYNC 16'hffd8
`define RVI_VEC_ASYNC 16'hffd6

`endif

// file: include/rvi_pkg.sv
/*
 * types of the reset and interrupt vectoring block.
 * assumes nothing beyond a systemverilog compiler.
 */
package rvi_pkg;

    // maskable sources, index = default priority minus 6
    typedef enum logic [4:0] {
        RVI_SRC_IRQ = 5'h00,
        RVI_SRC_RTI = 5'h01,
        RVI_SRC_CAP1 = 5'h02,
        RVI_SRC_CAP2 = 5'h03,
        RVI_SRC_CAP3 = 5'h04,
        RVI_SRC_CMP1 = 5'h05,
        RVI_SRC_CMP2 = 5'h06,
        RVI_SRC_CMP3 = 5'h07,
        RVI_SRC_CMP4 = 5'h08,
        RVI_SRC_CAP4 = 5'h09,
        RVI_SRC_TOVF = 5'h0a,
        RVI_SRC_AOVF = 5'h0b,
        RVI_SRC_AEDGE = 5'h0c,
        RVI_SRC_SYNC = 5'h0d,
        RVI_SRC_RXF = 5'h0e,
        RVI_SRC_OVR = 5'h0f,
        RVI_SRC_TXE = 5'h10,
        RVI_SRC_TXC = 5'h11,
        RVI_SRC_IDLE = 5'h12
    } rvi_src_t;

    // peripheral flags in default priority order; bit 0 is the pin
    typedef struct packed {
        logic idle;
        logic tx_done;
        logic tx_empty;
        logic overrun;
        logic rx_full;
        logic sync_done;
        logic accum_edge;
        logic accum_ovf;
        logic timer_ovf;
        logic cap4_cmp5;
        logic cmp4;
        logic cmp3;
        logic cmp2;
        logic cmp1;
        logic cap3;
        logic cap2;
        logic cap1;
        logic periodic;
        logic pin;
    } rvi_flags_t;

    // core request towards the processor
    typedef struct packed {
        logic reset_req;
        logic nmi_req;
        logic irq_req;
        logic [15:0] vector;
    } rvi_core_req_t;

    typedef enum logic [2:0] {
        RVI_RST_NONE = 3'b001,
        RVI_RST_CLKMON = 3'b010,
        RVI_RST_WDOG = 3'b100
    } rvi_rst_state_t;

endpackage

// file: rtl/rvi_vectoring.sv
/*
 * reset and interrupt vectoring: source gating, priority with
 * promotion, vector supply, option register with write-once window,
 * watchdog and clock monitor resets.
 * assumes the core samples core_req each cycle and drives the
 * instruction-level trap strobes and the register port on mclk.
 */
//
// Contract
// - three reset vectors with fixed priority
// - 22 sources onto 18 vectors
// - nonmaskable: pin gated by X, trap, swi
// - maskable recognised only with I clear
// - fixed order, one source promoted
// - promotion writes only while I set
// - local enables gate all but pin request
// - serial unit five sources share one vector
// - rx flag clears on status-then-data read
// - sync serial on its vector, enabled
// - accumulator edge and overflow vectors
// - timer overflow and cap4/cmp5 vectors
// - output compare 4..1 vectors
// - input capture 3..1 vectors
// - periodic, pin request, nonmaskable pin vectors
// - swi and trap vectors, unmaskable
// - option protected bits write once early
// - pin request level or falling edge
// - promotion codes, reserved default to pin
// - monitor enable makes clock failure reset
// - forced monitor holds until reset
// - 55 then aa restarts watchdog
`timescale 1ns/10ps
`include "rvi_defines.svh"

module rvi_vectoring #(
    parameter int WD_BASE_CYCLES = 32768,
    parameter int CLK_FAIL_CYCLES = 4096
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic special_mode,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic irq_pin_n,
    input wire logic nmi_pin_n,
    input wire logic osc_tick,
    input wire logic watchdog_disable_cfg,
    input wire logic swi_exec,
    input wire logic trap_exec,
    input wire rvi_pkg::rvi_flags_t periph_flags,
    input wire logic rx_flag_set,
    output rvi_pkg::rvi_core_req_t core_req
);

    logic [1:0] irq_sync_reg, nmi_sync_reg, tick_sync_reg;
    logic irq_prev_reg, irq_edge_reg, tick_prev_reg;
    logic [7:0] option_reg, condition_code_reg;
    logic [4:0] priority_promote_reg;
    logic [18:0] enable_reg;
    logic once_done_reg;
    logic [6:0] once_cnt_reg;
    logic wd_armed_reg;
    logic [22:0] wd_cnt_reg;
    logic mon_forced_reg;
    logic [12:0] mon_cnt_reg;
    logic rx_full_flag, status_seen_reg;
    rvi_pkg::rvi_rst_state_t rst_state_reg;
    logic [15:0] vector_next;
    logic [18:0] pending;
    logic [4:0] promoted;
    logic nmi_act, mask_i, wd_timeout, mon_fail;

    // pins come from outside the clock domain
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_sync_reg <= 2'h3;
            nmi_sync_reg <= 2'h3;
            tick_sync_reg <= 2'h0;
        end else begin
            irq_sync_reg <= {irq_sync_reg[0], irq_pin_n};
            nmi_sync_reg <= {nmi_sync_reg[0], nmi_pin_n};
            tick_sync_reg <= {tick_sync_reg[0], osc_tick};
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_prev_reg <= 1'b1;
            irq_edge_reg <= 1'b0;
        end else begin
            irq_prev_reg <= irq_sync_reg[1];
            if (irq_prev_reg && !irq_sync_reg[1])
                irq_edge_reg <= 1'b1;
            else if (core_req.irq_req && core_req.vector == `RVI_VEC_IRQ)
                irq_edge_reg <= 1'b0;
        end
    end

    // serial receive flag, set wins over the clearing read
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_full_flag <= 1'b0;
            status_seen_reg <= 1'b0;
        end else begin
            if (reg_rd && reg_addr == `RVI_OFF_SER_STATUS)
                status_seen_reg <= rx_full_flag;
            else if (reg_rd && reg_addr == `RVI_OFF_SER_DATA)
                status_seen_reg <= 1'b0;
            if (rx_flag_set)
                rx_full_flag <= 1'b1;
            else if (reg_rd && reg_addr == `RVI_OFF_SER_DATA && status_seen_reg)
                rx_full_flag <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            once_cnt_reg <= 7'h00;
        else if (once_cnt_reg != 7'(`RVI_ONCE_CYCLES))
            once_cnt_reg <= once_cnt_reg + 7'h01;
    end

    // option register, protected bits once early in normal modes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            option_reg <= `RVI_OPT_RESET;
            once_done_reg <= 1'b0;
        end else if (reg_wr && reg_addr == `RVI_OFF_OPTION) begin
            if (special_mode ||
                (!once_done_reg && once_cnt_reg != 7'(`RVI_ONCE_CYCLES))) begin
                option_reg <= reg_wdata;
                once_done_reg <= 1'b1;
            end else begin
                option_reg <= (option_reg & `RVI_OPT_ONCE_MASK) |
                              (reg_wdata & ~`RVI_OPT_ONCE_MASK);
            end
        end
    end

    // promotion field writable only with I set
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            priority_promote_reg <= `RVI_PROMOTE_RESET;
        else if (reg_wr && reg_addr == `RVI_OFF_PROMOTE && condition_code_reg[`RVI_CCR_I])
            priority_promote_reg <= reg_wdata[4:0];
    end

    // core mirror of its mask bits; X may only be cleared, never set
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            condition_code_reg <= `RVI_CCR_RESET;
        else if (reg_wr && reg_addr == `RVI_OFF_CCR)
            condition_code_reg <= {reg_wdata[7],
                reg_wdata[`RVI_CCR_X] & condition_code_reg[`RVI_CCR_X], reg_wdata[5:0]};
    end

    // local enables, bit 0 (pin request) has none and stays set
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            enable_reg <= 19'h00001;
        else if (reg_wr && reg_addr == `RVI_OFF_ENABLE_LO)
            enable_reg[7:0] <= {reg_wdata[7:1], 1'b1};
        else if (reg_wr && reg_addr == `RVI_OFF_ENABLE_HI)
            enable_reg[18:8] <= {enable_reg[18:16], reg_wdata};
        else if (reg_wr && reg_addr == `RVI_OFF_PENDING_HI)
            enable_reg[18:16] <= reg_wdata[2:0];
    end

    // watchdog: arm with 55, restart with aa
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wd_armed_reg <= 1'b0;
            wd_cnt_reg <= 23'h0;
        end else if (reg_wr && reg_addr == `RVI_OFF_WD_SERVICE) begin
            if (reg_wdata == `RVI_WD_ARM)
                wd_armed_reg <= 1'b1;
            else if (reg_wdata == `RVI_WD_CLEAR && wd_armed_reg) begin
                wd_armed_reg <= 1'b0;
                wd_cnt_reg <= 23'h0;
            end
        end else if (!watchdog_disable_cfg && !wd_timeout)
            wd_cnt_reg <= wd_cnt_reg + 23'h1;
    end

    // rate bits scale by four per step
    assign wd_timeout = wd_cnt_reg >= 23'(WD_BASE_CYCLES <<
        (2 * {option_reg[`RVI_OPT_RATE_HI], option_reg[`RVI_OPT_RATE_LO]}));

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            mon_forced_reg <= 1'b0;
        else if (option_reg[`RVI_OPT_FORCE_MON])
            mon_forced_reg <= 1'b1;
    end

    // oscillator ticks restart the monitor count
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            tick_prev_reg <= 1'b0;
        else
            tick_prev_reg <= tick_sync_reg[1];
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            mon_cnt_reg <= 13'h0;
        else if (tick_sync_reg[1] != tick_prev_reg ||
                 !(option_reg[`RVI_OPT_MON_EN] || mon_forced_reg))
            mon_cnt_reg <= 13'h0;
        else if (!mon_fail)
            mon_cnt_reg <= mon_cnt_reg + 13'h1;
    end

    assign mon_fail = mon_cnt_reg >= 13'(CLK_FAIL_CYCLES);

    // reset source, clock failure above watchdog
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            rst_state_reg <= rvi_pkg::RVI_RST_NONE;
        else if (mon_fail)
            rst_state_reg <= rvi_pkg::RVI_RST_CLKMON;
        else if (wd_timeout && !watchdog_disable_cfg)
            rst_state_reg <= rvi_pkg::RVI_RST_WDOG;
    end

    // local gating; pin by level or edge
    always_comb begin
        pending = {periph_flags.idle, periph_flags.tx_done, periph_flags.tx_empty,
                   periph_flags.overrun, rx_full_flag | periph_flags.rx_full,
                   periph_flags.sync_done, periph_flags.accum_edge,
                   periph_flags.accum_ovf, periph_flags.timer_ovf,
                   periph_flags.cap4_cmp5, periph_flags.cmp4, periph_flags.cmp3,
                   periph_flags.cmp2, periph_flags.cmp1, periph_flags.cap3,
                   periph_flags.cap2, periph_flags.cap1, periph_flags.periodic,
                   option_reg[`RVI_OPT_SENSE] ? irq_edge_reg : !irq_sync_reg[1]}
                  & enable_reg;
    end

    // promotion decode, reserved codes fall to pin request
    always_comb begin
        if (priority_promote_reg >= 5'h06 && priority_promote_reg <= 5'h13)
            promoted = priority_promote_reg - 5'h06;
        else if (priority_promote_reg == 5'h14)
            promoted = 5'h0e;
        else
            promoted = 5'h00;
    end

    assign mask_i = condition_code_reg[`RVI_CCR_I];
    assign nmi_act = !nmi_sync_reg[1] && !condition_code_reg[`RVI_CCR_X];

    function automatic logic [15:0] rvi_vec_of(input logic [4:0] idx);
        case (idx)
            5'h00: rvi_vec_of = `RVI_VEC_IRQ;
            5'h01: rvi_vec_of = `RVI_VEC_RTI;
            5'h02: rvi_vec_of = `RVI_VEC_CAP1;
            5'h03: rvi_vec_of = `RVI_VEC_CAP2;
            5'h04: rvi_vec_of = `RVI_VEC_CAP3;
            5'h05: rvi_vec_of = `RVI_VEC_CMP1;
            5'h06: rvi_vec_of = `RVI_VEC_CMP2;
            5'h07: rvi_vec_of = `RVI_VEC_CMP3;
            5'h08: rvi_vec_of = `RVI_VEC_CMP4;
            5'h09: rvi_vec_of = `RVI_VEC_CAP4;
            5'h0a: rvi_vec_of = `RVI_VEC_TOVF;
            5'h0b: rvi_vec_of = `RVI_VEC_AOVF;
            5'h0c: rvi_vec_of = `RVI_VEC_AEDGE;
            5'h0d: rvi_vec_of = `RVI_VEC_SYNC;
            default: rvi_vec_of = `RVI_VEC_ASYNC;
        endcase
    endfunction

    always_comb begin
        vector_next = 16'h0000;
        if (rst_state_reg == rvi_pkg::RVI_RST_CLKMON)
            vector_next = `RVI_VEC_CLKMON;
        else if (rst_state_reg == rvi_pkg::RVI_RST_WDOG)
            vector_next = `RVI_VEC_WDOG;
        else if (trap_exec)
            vector_next = `RVI_VEC_TRAP;
        else if (swi_exec)
            vector_next = `RVI_VEC_SWI;
        else if (nmi_act)
            vector_next = `RVI_VEC_NMI;
        else if (!mask_i && pending[promoted])
            vector_next = rvi_vec_of(promoted);
        else if (!mask_i) begin
            for (int k = 18; k >= 0; k--)
                if (pending[k])
                    vector_next = rvi_vec_of(5'(k));
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            core_req <= '{reset_req: 1'b1, nmi_req: 1'b0, irq_req: 1'b0,
                          vector: `RVI_VEC_POR};
        else begin
            core_req.reset_req <= rst_state_reg != rvi_pkg::RVI_RST_NONE;
            core_req.nmi_req <= rst_state_reg == rvi_pkg::RVI_RST_NONE &&
                                (trap_exec || swi_exec || nmi_act);
            core_req.irq_req <= rst_state_reg == rvi_pkg::RVI_RST_NONE &&
                                !(trap_exec || swi_exec || nmi_act) &&
                                !mask_i && pending != 19'h0;
            core_req.vector <= vector_next == 16'h0000 ? `RVI_VEC_POR : vector_next;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (reg_rd) begin
            case (reg_addr)
                `RVI_OFF_OPTION: reg_rdata <= option_reg;
                `RVI_OFF_PROMOTE: reg_rdata <= {3'h0, priority_promote_reg};
                `RVI_OFF_CCR: reg_rdata <= condition_code_reg;
                `RVI_OFF_ENABLE_LO: reg_rdata <= enable_reg[7:0];
                `RVI_OFF_ENABLE_HI: reg_rdata <= enable_reg[15:8];
                `RVI_OFF_VECTOR_LO: reg_rdata <= core_req.vector[7:0];
                `RVI_OFF_VECTOR_HI: reg_rdata <= core_req.vector[15:8];
                `RVI_OFF_SER_STATUS: reg_rdata <= {rx_full_flag, 7'h00};
                `RVI_OFF_PENDING_LO: reg_rdata <= pending[7:0];
                `RVI_OFF_PENDING_HI: reg_rdata <= {rst_state_reg, enable_reg[18:16], 2'h0};
                default: reg_rdata <= 8'h00;
            endcase
        end else
            reg_rdata <= 8'h00;
    end

    promote_lock_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !$past(condition_code_reg[`RVI_CCR_I]) && $past(rst_n)
        |-> $stable(priority_promote_reg))
        else $error("promotion changed with mask clear");

    // no maskable request while I set
    mask_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
        mask_i ##1 mask_i |-> !core_req.irq_req)
        else $error("maskable request with mask set");

    reset_first_a: assert property (@(posedge mclk) disable iff (!rst_n)
        core_req.reset_req |->
            core_req.vector inside {`RVI_VEC_POR, `RVI_VEC_CLKMON, `RVI_VEC_WDOG})
        else $error("reset request with non-reset vector");

    // protected bits frozen after the window in normal mode
    option_once_a: assert property (@(posedge mclk) disable iff (!rst_n)
        once_cnt_reg == 7'(`RVI_ONCE_CYCLES) && !special_mode ##1 !special_mode
        |-> (option_reg & `RVI_OPT_ONCE_MASK) ==
            ($past(option_reg) & `RVI_OPT_ONCE_MASK))
        else $error("protected option bit changed late");

    forced_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        mon_forced_reg |=> mon_forced_reg [*4])
        else $error("forced monitor dropped");

    // trap gives nonmaskable request next cycle
    trap_vec_a: assert property (@(posedge mclk) disable iff (!rst_n)
        trap_exec && rst_state_reg == rvi_pkg::RVI_RST_NONE
        |=> core_req.nmi_req && core_req.vector == `RVI_VEC_TRAP)
        else $error("trap vector missing");

    rx_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
        reg_rd && reg_addr == `RVI_OFF_SER_STATUS && rx_full_flag && !rx_flag_set
        ##1 reg_rd && reg_addr == `RVI_OFF_SER_DATA && !rx_flag_set |=> !rx_full_flag)
        else $error("receive flag not cleared");

    wd_restart_a: assert property (@(posedge mclk) disable iff (!rst_n)
        reg_wr && reg_addr == `RVI_OFF_WD_SERVICE && reg_wdata == `RVI_WD_CLEAR
        && wd_armed_reg |=> wd_cnt_reg == 23'h0)
        else $error("watchdog not restarted");

endmodule // rvi_vectoring

// file: test/rvi_core_model.sv
/* core stand-in: drives the trap and software-interrupt levels, latches the fetch vector.
   assumes core_req is registered on mclk. */
`timescale 1ns/10ps
module rvi_core_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire rvi_pkg::rvi_core_req_t core_req,
    input wire logic [1:0] exec_cmd,
    output logic swi_exec,
    output logic trap_exec,
    output logic [15:0] fetch_vec
);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            swi_exec <= 1'b0;
            trap_exec <= 1'b0;
        end else begin
            swi_exec <= exec_cmd[0];
            trap_exec <= exec_cmd[1];
        end
    end
    // fetch from supplied vector
    // latched so a check may follow the fetch a few cycles late
    always_ff @(posedge mclk) begin
        if (core_req.reset_req || core_req.nmi_req || core_req.irq_req) begin
            fetch_vec <= core_req.vector;
        end
    end
endmodule // rvi_core_model

// file: test/rvi_vectoring_tb.sv
/* bench for the vectoring block: register port tasks, vectors, masking, promotion,
   pin sense and reset sources. assumes the core stand-in and shortened counts. */
`timescale 1ns/10ps
`include "rvi_defines.svh"
module rvi_vectoring_tb;
    logic mclk, rst_n, special_mode, reg_wr, reg_rd, irq_pin_n, nmi_pin_n;
    logic osc_tick, osc_run, wd_off, rx_set, swi_exec, trap_exec;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic [1:0] exec_cmd;
    logic [15:0] fetch_vec;
    rvi_pkg::rvi_flags_t flags;
    rvi_pkg::rvi_core_req_t core_req;
    int n_fail, comparisons, cyc;

    rvi_vectoring #(.WD_BASE_CYCLES(16), .CLK_FAIL_CYCLES(8)) dut_u (
        .mclk(mclk), .rst_n(rst_n), .special_mode(special_mode), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq_pin_n(irq_pin_n), .nmi_pin_n(nmi_pin_n), .osc_tick(osc_tick),
        .watchdog_disable_cfg(wd_off), .swi_exec(swi_exec), .trap_exec(trap_exec),
        .periph_flags(flags), .rx_flag_set(rx_set), .core_req(core_req));
    rvi_core_model core_u (.mclk(mclk), .rst_n(rst_n), .core_req(core_req),
        .exec_cmd(exec_cmd), .swi_exec(swi_exec), .trap_exec(trap_exec), .fetch_vec(fetch_vec));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (osc_run) osc_tick <= ~osc_tick;
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            close_out();
        end
    end

    task automatic close_out();
        if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [18:0] exp, input logic [18:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic rc(input string nm, input logic [3:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        chk(nm, {11'h0, e}, {11'h0, v});
    endtask
    task automatic set_in(input logic [18:0] f, input logic ip, input logic np,
                          input logic [1:0] ex, input logic rx);
        @(posedge mclk);
        flags <= f;
        irq_pin_n <= ip;
        nmi_pin_n <= np;
        exec_cmd <= ex;
        rx_set <= rx;
    endtask
    // no request expected means the vector is not looked at
    task automatic req(input string nm, input logic [2:0] r, input logic [15:0] v);
        int i;
        i = 0;
        repeat (2) @(posedge mclk);
        do begin
            @(posedge mclk);
            #1;
            i++;
        end while ((r == 3'b0 || core_req[18:16] !== r) && i < 22);
        chk(nm, {r, v}, {core_req[18:16], r == 3'b0 ? 16'h0 : core_req.vector});
    endtask
    task automatic prom(input logic [7:0] code);
        wr(`RVI_OFF_CCR, 8'h50);
        wr(`RVI_OFF_PROMOTE, code);
        wr(`RVI_OFF_CCR, 8'h40);
    endtask

    initial begin
        {special_mode, reg_wr, reg_rd, reg_addr, reg_wdata, osc_tick, rx_set} = '0;
        {irq_pin_n, nmi_pin_n, osc_run, wd_off} = 4'hf;
        flags = '0;
        exec_cmd = 2'h0;
        rst_n = 1'b0;
        {n_fail, comparisons, cyc} = '0;
        repeat (2) @(posedge mclk);
        #1;
        chk("rst req", {3'b100, `RVI_VEC_POR}, core_req);
        chk("rst fetch", {3'b0, `RVI_VEC_POR}, fetch_vec);
        @(posedge mclk);
        rst_n <= 1'b1;
        rc("opt rst", `RVI_OFF_OPTION, `RVI_OPT_RESET);
        rc("ccr rst", `RVI_OFF_CCR, `RVI_CCR_RESET);
        wr(`RVI_OFF_OPTION, 8'h20);
        wr(`RVI_OFF_OPTION, 8'h1b);
        rc("opt once", `RVI_OFF_OPTION, 8'h28);
        wr(`RVI_OFF_CCR, 8'h40);
        set_in(19'h0, 1'b0, 1'b1, 2'h0, 1'b0);
        req("pin edge", 3'b001, `RVI_VEC_IRQ);
        req("pin edge once", 3'b000, 16'h0);
        set_in(19'h0, 1'b1, 1'b1, 2'h0, 1'b0);
        special_mode <= 1'b1;
        wr(`RVI_OFF_OPTION, 8'h08);
        rc("opt special", `RVI_OFF_OPTION, 8'h08);
        set_in(19'h0, 1'b0, 1'b1, 2'h0, 1'b0);
        req("pin level", 3'b001, `RVI_VEC_IRQ);
        req("pin held", 3'b001, `RVI_VEC_IRQ);
        set_in(19'h0, 1'b1, 1'b1, 2'h0, 1'b0);
        wr(`RVI_OFF_ENABLE_LO, 8'hff);
        wr(`RVI_OFF_ENABLE_HI, 8'hff);
        wr(`RVI_OFF_PENDING_HI, 8'h07);
        for (int s = 1; s < 19; s++) begin
            if (s == 14) continue;
            set_in(19'h1 << s, 1'b1, 1'b1, 2'h0, 1'b0);
            req("src vec", 3'b001, s > 14 ? `RVI_VEC_ASYNC : 16'hfff2 - 16'(2 * s));
        end
        wr(`RVI_OFF_ENABLE_LO, 8'h00);
        set_in(19'h4, 1'b1, 1'b1, 2'h0, 1'b0);
        req("local mask", 3'b000, 16'h0);
        wr(`RVI_OFF_ENABLE_LO, 8'hff);
        req("local on", 3'b001, `RVI_VEC_CAP1);
        wr(`RVI_OFF_CCR, 8'h50);
        req("global mask", 3'b000, 16'h0);
        wr(`RVI_OFF_CCR, 8'h40);
        set_in(19'h104, 1'b1, 1'b1, 2'h0, 1'b0);
        req("default order", 3'b001, `RVI_VEC_CAP1);
        wr(`RVI_OFF_PROMOTE, 8'h0e);
        req("promote refused", 3'b001, `RVI_VEC_CAP1);
        prom(8'h0e);
        req("promoted", 3'b001, `RVI_VEC_CMP4);
        prom(8'h15);
        req("reserved code", 3'b001, `RVI_VEC_CAP1);
        prom(8'h14);
        set_in(19'h4, 1'b1, 1'b1, 2'h0, 1'b1);
        set_in(19'h4, 1'b1, 1'b1, 2'h0, 1'b0);
        req("serial promoted", 3'b001, `RVI_VEC_ASYNC);
        rd(`RVI_OFF_SER_DATA, d);
        rd(`RVI_OFF_SER_STATUS, d);
        chk("rx kept", 19'h1, {18'h0, d[7]});
        rd(`RVI_OFF_SER_DATA, d);
        req("rx cleared", 3'b001, `RVI_VEC_CAP1);
        set_in(19'h0, 1'b1, 1'b0, 2'h0, 1'b0);
        req("nmi gated", 3'b000, 16'h0);
        wr(`RVI_OFF_CCR, 8'h10);
        req("nmi pin", 3'b010, `RVI_VEC_NMI);
        for (int k = 1; k < 3; k++) begin
            set_in(19'h0, 1'b1, 1'b1, 2'(k), 1'b0);
            repeat (4) @(posedge mclk);
            #1;
            chk("trap vec", {3'b0, k == 1 ? `RVI_VEC_SWI : `RVI_VEC_TRAP}, fetch_vec);
        end
        set_in(19'h0, 1'b1, 1'b1, 2'h0, 1'b0);
        osc_run <= 1'b0;
        req("clock fail", 3'b100, `RVI_VEC_CLKMON);
        @(posedge mclk);
        rst_n <= 1'b0;
        osc_run <= 1'b1;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        wr(`RVI_OFF_OPTION, 8'h04);
        rc("opt forced", `RVI_OFF_OPTION, 8'h04);
        wd_off <= 1'b0;
        repeat (6) begin
            wr(`RVI_OFF_WD_SERVICE, `RVI_WD_ARM);
            wr(`RVI_OFF_WD_SERVICE, `RVI_WD_CLEAR);
            repeat (6) @(posedge mclk);
        end
        #1;
        chk("wd served", 19'h0, {18'h0, core_req.reset_req});
        req("wd fail", 3'b100, `RVI_VEC_WDOG);
        close_out();
    end
endmodule // rvi_vectoring_tb
